// ==== core/gfs_pkg.sv ====
// Package for the gate firing self-test sequencer.
// Holds event codes, fire patterns, timing counts, state and carrier types.
// Assumes a single 100 MHz controller clock shared by every user of it.
package gfs_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_FREQ_HZ   = 100_000_000;        // Controller clock rate
  localparam int unsigned CYC_PER_MS    = CLK_FREQ_HZ / 1000; // Cycles in one millisecond
  localparam int unsigned STEP_TIME_MS  = 10_000;             // Default length of one test step
  localparam int unsigned STEP_CYCLES   = STEP_TIME_MS * CYC_PER_MS; // Step length in cycles

  // ==========================================================================
  // Event log codes
  // ==========================================================================
  localparam logic [7:0] EVT_ENTERED    = 8'hc1; // Standard self-test entered (193)
  localparam logic [7:0] EVT_PASSED     = 8'hc3; // Self-test passed (195)
  localparam logic [7:0] FLT_DISCONNECT = 8'h3c; // Fault: isolating switch closed mid-test
  localparam logic [7:0] FLT_LINE_POWER = 8'h3d; // Fault: line power seen mid-test
  localparam logic [7:0] FLT_CMD_GONE   = 8'h3e; // Fault: self-test command withdrawn

  // ==========================================================================
  // Gate order and string positions
  // ==========================================================================
  localparam int unsigned NUM_GATES  = 6;           // Gate strings / sequential steps
  localparam int unsigned NUM_PHASES = 3;           // Phases of the starter
  localparam logic [2:0]  LAST_STEP  = 3'h5;        // Index of the final sequential step
  localparam logic [5:0]  POS_ODD    = 6'h15;       // Positions A, C, E (bit 0 is A)
  localparam logic [5:0]  POS_EVEN   = 6'h2a;       // Positions B, D, F
  localparam logic [5:0]  POS_NO_EF  = 6'h0f;       // Lower voltage build drops E and F
  localparam logic [5:0]  NO_GATES   = 6'h00;       // Every position off
  localparam logic [17:0] GATE_ORDER = 18'h0c55e;   // Gate numbers 6,3,5,2,4,1, first in low bits

  // ==========================================================================
  // Types
  // ==========================================================================
  // Sequencer states, Gray coded along the main path
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_PROMPT = 3'h1,
    ST_SEQ    = 3'h3,
    ST_ALL    = 3'h2,
    ST_PASS   = 3'h6,
    ST_RESET  = 3'h7,
    ST_DONE   = 3'h5,
    ST_ABORT  = 3'h4
  } gfs_state_e;

  // What the status display is told to show
  typedef enum logic [2:0] {
    DSP_HOME     = 3'h0,
    DSP_OPEN_SW  = 3'h1,
    DSP_GATE_ON  = 3'h2,
    DSP_ALL_ON   = 3'h3,
    DSP_PASSED   = 3'h4,
    DSP_CANCEL   = 3'h5
  } gfs_disp_e;

  // Fire pattern: per phase, six series positions A..F
  typedef logic [NUM_PHASES-1:0][5:0] gfs_fire_t;

  // Display message with gate number
  typedef struct packed {
    gfs_disp_e  mode;   // Message selector
    logic [2:0] gate;   // Gate string number 1..6, zero when none
  } gfs_disp_s;

  // One event log entry
  typedef struct packed {
    logic        valid; // One-cycle strobe
    logic [7:0]  code;  // Event or fault number
    logic [31:0] stamp; // Timestamp in clock cycles
  } gfs_log_s;

endpackage

// ==== core/gfs_sequencer.sv ====
// Gate firing self-test sequencer: steps the six gate strings one at a time,
// then all together, logs pass or cancel events and, after a pass, requests a system reset.
// Assumes the pushbutton and safety inputs are asynchronous pins and that the
// gate driver cards act on the fire pattern level directly.
//
// Operation
// R01: Fire gates singly in order 6,3,5,2,4,1
// R02: Map each gate to one phase string half
// R03: Show self-test mode and current gate number
// R04: Advance press ends step, moves to next
// R05: Lower voltage build omits E and F positions
// R06: Then fire all gates, show all-on message
// R07: Press in all-gates step finishes the test
// R08: On completion log 195, then reset system
// R09: Abort on switch, line power, command loss
// R10: Fault entries carry only code and timestamp
// R11: On entry log 193, prompt if switch closed
// R12: Each step ends itself after its duration
// R13: Gates off outside steps and after abort
// R14: Cancel within one clock, no further firing; gates drop three edges after the input changes
module gfs_sequencer
  import gfs_pkg::*;
#(
  parameter int unsigned STEP_LEN = STEP_CYCLES  // Step length in cycles, shorten in simulation
)
(
  input  wire logic      sys_clk_i,                   // Controller clock, 100 MHz
  input  wire logic      resetn_i,                    // Synchronous reset, active low
  input  wire logic      standard_selftest_command_i, // Self-test command level, async
  input  wire logic      advance_btn_i,               // Operator advance pushbutton, async
  input  wire logic      disconnect_closed_i,         // Isolating switch closed, async
  input  wire logic      line_power_i,                // Line voltage present, async
  input  wire logic      low_voltage_build_i,         // Lower voltage build strap, async
  output gfs_fire_t      gate_fire_o,                 // Per-phase position fire pattern
  output logic [5:0]     gate_on_o,                   // Gate string n energised on bit n-1
  output gfs_disp_s      disp_o,                      // Display message
  output gfs_log_s       log_o,                       // Event log entry strobe
  output logic           sys_reset_req_o,             // One-cycle system reset request
  output logic           test_active_o                // Self-test in progress
);

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  // Gate number for a sequential step index
  function automatic logic [2:0] gate_of_step(input logic [2:0] idx);
    logic [2:0] g;
    g = 3'h0;
    for (int i = 0; i < NUM_GATES; i++)
    begin
      if (idx == 3'(i))
      begin
        g = GATE_ORDER[3*i +: 3];
      end
    end
    return g;
  endfunction

  // Fire pattern for one gate string
  function automatic gfs_fire_t fire_of_gate(input logic [2:0] gate, input logic low_v);
    gfs_fire_t  f;
    logic [5:0] pos;
    f   = '0;
    pos = gate[0] ? POS_ODD : POS_EVEN;                  // [R02]
    if (low_v)
    begin
      pos = pos & POS_NO_EF;                             // [R05]
    end
    // Gates 6,3 on phase 1; 5,2 on phase 2; 4,1 on phase 3
    unique case (gate)
      3'h6, 3'h3: f[0] = pos;                            // [R02]
      3'h5, 3'h2: f[1] = pos;                            // [R02]
      3'h4, 3'h1: f[2] = pos;                            // [R02]
      default:    f    = '0;                             // Zero and seven fire nothing
    endcase
    return f;
  endfunction

  // Pattern with every gate string fired, built by a generate loop
  gfs_fire_t all_fire;                                   // All strings on
  gfs_fire_t all_fire_lo;                                // All strings on, lower voltage
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PHASES; gi++)
    begin : g_all
      assign all_fire[gi]    = POS_ODD | POS_EVEN;
      assign all_fire_lo[gi] = (POS_ODD | POS_EVEN) & POS_NO_EF;
    end
  endgenerate

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [4:0]  sync1;    // First synchroniser stage, read only by sync2
    logic [4:0]  sync2;    // Second stage: cmd, btn, disc, line, lowv
    logic        btn_prev; // Previous button level for edge detection
    gfs_state_e  state;    // Sequencer state
    logic [2:0]  step;     // Sequential step index 0..5
    logic [31:0] timer;    // Cycles left in current step
    logic [31:0] now;      // Free running timestamp
    gfs_fire_t   fire;     // Registered fire pattern
    logic [5:0]  gate_on;  // Registered gate-on flags
    gfs_disp_s   disp;     // Registered display message
    gfs_log_s    log;      // Registered log strobe
    logic        rst_req;  // Registered reset request
  } gfs_core_s;

  gfs_core_s core_q;   // Registered state
  gfs_core_s core_d;   // Next state

  // Synchronised input views
  logic cmd;           // Self-test command
  logic btn;           // Pushbutton level
  logic disc;          // Switch closed
  logic line;          // Line power
  logic lowv;          // Lower voltage build
  logic press;         // Pushbutton rising edge
  logic step_done;     // Step ends by press or timeout
  logic unsafe;        // Any abort condition in a running step
  logic [7:0] cause;   // Fault code for the abort

  assign cmd   = core_q.sync2[0];
  assign btn   = core_q.sync2[1];
  assign disc  = core_q.sync2[2];
  assign line  = core_q.sync2[3];
  assign lowv  = core_q.sync2[4];
  assign press = btn & ~core_q.btn_prev;

  // Step ends on a press or when its timer runs out
  assign step_done = press                               // [R04]
                   | (core_q.timer == 32'h0000_0000);    // [R12]

  // Abort conditions; switch closed counts only once the test is running
  assign unsafe = ~cmd | line | disc;                    // [R09]

  // Cause priority: command loss, then line power, then switch
  always_comb
  begin
    if (~cmd)
    begin
      cause = FLT_CMD_GONE;
    end
    else if (line)
    begin
      cause = FLT_LINE_POWER;
    end
    else
    begin
      cause = FLT_DISCONNECT;
    end
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Fire, gate-on, log strobe and reset request are rebuilt every cycle so any state without firing leaves gates off
  always_comb
  begin
    core_d           = core_q;
    core_d.sync1     = {low_voltage_build_i, line_power_i, disconnect_closed_i,
                        advance_btn_i, standard_selftest_command_i};
    core_d.sync2     = core_q.sync1;
    core_d.btn_prev  = btn;
    core_d.now       = core_q.now + 32'h0000_0001;
    core_d.fire      = '0;                               // [R13]
    core_d.gate_on   = NO_GATES;                         // [R13]
    core_d.log.valid = 1'b0;
    core_d.rst_req   = 1'b0;
    if (core_q.timer != 32'h0000_0000)
    begin
      core_d.timer = core_q.timer - 32'h0000_0001;
    end

    unique case (core_q.state)
      // Wait for the command to be raised
      ST_IDLE:
      begin
        core_d.disp = '{mode: DSP_HOME, gate: 3'h0};
        if (cmd)
        begin
          core_d.log   = '{valid: 1'b1, code: EVT_ENTERED, stamp: core_q.now}; // [R11]
          core_d.state = ST_PROMPT;
        end
      end

      // Hold until the isolating switch is open
      ST_PROMPT:
      begin
        if (~cmd | line)
        begin
          core_d.log   = '{valid: 1'b1, code: cause, stamp: core_q.now}; // [R09]
          core_d.disp  = '{mode: DSP_CANCEL, gate: 3'h0};
          core_d.state = ST_ABORT;
        end
        else if (disc)
        begin
          core_d.disp = '{mode: DSP_OPEN_SW, gate: 3'h0};               // [R11]
        end
        else
        begin
          core_d.step    = 3'h0;
          core_d.timer   = STEP_LEN;
          core_d.fire    = fire_of_gate(gate_of_step(3'h0), lowv);      // [R01]
          core_d.gate_on = 6'h01 << (gate_of_step(3'h0) - 3'h1);
          core_d.disp    = '{mode: DSP_GATE_ON, gate: gate_of_step(3'h0)};
          core_d.state   = ST_SEQ;
        end
      end

      // One gate string at a time
      ST_SEQ:
      begin
        if (unsafe)
        begin
          // Gates already cleared above, so the drive stops on the next edge
          core_d.log   = '{valid: 1'b1, code: cause, stamp: core_q.now}; // [R14] [R10]
          core_d.disp  = '{mode: DSP_CANCEL, gate: 3'h0};
          core_d.state = ST_ABORT;
        end
        else if (step_done && core_q.step == LAST_STEP)
        begin
          core_d.timer = STEP_LEN;
          core_d.fire  = lowv ? all_fire_lo : all_fire;                  // [R06] [R05]
          core_d.gate_on = 6'h3f;
          core_d.disp  = '{mode: DSP_ALL_ON, gate: 3'h0};                // [R06]
          core_d.state = ST_ALL;
        end
        else
        begin
          if (step_done)
          begin
            core_d.step  = core_q.step + 3'h1;                           // [R04]
            core_d.timer = STEP_LEN;
          end
          core_d.fire    = fire_of_gate(gate_of_step(core_d.step), lowv); // [R01]
          core_d.gate_on = 6'h01 << (gate_of_step(core_d.step) - 3'h1);
          core_d.disp    = '{mode: DSP_GATE_ON, gate: gate_of_step(core_d.step)}; // [R03]
        end
      end

      // Every gate string together
      ST_ALL:
      begin
        if (unsafe)
        begin
          core_d.log   = '{valid: 1'b1, code: cause, stamp: core_q.now}; // [R14] [R10]
          core_d.disp  = '{mode: DSP_CANCEL, gate: 3'h0};
          core_d.state = ST_ABORT;
        end
        else if (step_done)
        begin
          // Leave the all-on message behind with the gates, never show it while dark
          core_d.disp  = '{mode: DSP_PASSED, gate: 3'h0};
          core_d.state = ST_PASS;                                        // [R07]
        end
        else
        begin
          core_d.fire    = lowv ? all_fire_lo : all_fire;                // [R06]
          core_d.gate_on = 6'h3f;
        end
      end

      // Record the pass, reset follows next cycle
      ST_PASS:
      begin
        core_d.log   = '{valid: 1'b1, code: EVT_PASSED, stamp: core_q.now}; // [R08]
        core_d.disp  = '{mode: DSP_PASSED, gate: 3'h0};
        core_d.state = ST_RESET;
      end

      // Issue the system reset request
      ST_RESET:
      begin
        core_d.rst_req = 1'b1;                                           // [R08]
        core_d.state   = ST_DONE;
      end

      // Passed or cancelled: gates stay off until the command drops
      ST_DONE, ST_ABORT:
      begin
        if (~cmd)
        begin
          core_d.disp  = '{mode: DSP_HOME, gate: 3'h0};
          core_d.state = ST_IDLE;
        end
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      core_q <= '{state: ST_IDLE, disp: '{mode: DSP_HOME, gate: 3'h0}, default: '0};
    end
    else
    begin
      core_q <= core_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign gate_fire_o     = core_q.fire;
  assign gate_on_o       = core_q.gate_on;
  assign disp_o          = core_q.disp;
  assign log_o           = core_q.log;
  assign sys_reset_req_o = core_q.rst_req;
  assign test_active_o   = (core_q.state == ST_SEQ) | (core_q.state == ST_ALL);

endmodule

// ==== tb/gfs_operator_model.sv ====
// Operator model: turns a one-cycle request into a full pushbutton press.
// Assumes requests arrive only while busy_o is low.
module gfs_operator_model
#(
  parameter int HOLD = 3 // Cycles pressed, then as many released
)
(
  input  wire logic sys_clk_i,
  input  wire logic press_req_i,
  output logic      advance_btn_o,
  output logic      busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0; // Remaining press and release cycles

  // Released time keeps the synchroniser from merging two presses
  always @(posedge sys_clk_i)
  begin
    if (press_req_i && cnt == 0)
      cnt <= 2 * HOLD;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign advance_btn_o = cnt > HOLD;
  assign busy_o        = cnt != 0;
endmodule

// ==== tb/gfs_seq_props.sv ====
// Checker for the gate firing self-test sequencer, bound to its top module.
// Assumes it sees only the sequencer ports and shares its single clock.
module gfs_seq_props
  import gfs_pkg::*;
#(
  parameter int unsigned STEP_LEN = STEP_CYCLES // Step length in cycles
)
(
  input wire logic       sys_clk_i,
  input wire logic       resetn_i,
  input wire logic       standard_selftest_command_i,
  input wire logic       advance_btn_i,
  input wire logic       disconnect_closed_i,
  input wire logic       line_power_i,
  input wire logic       low_voltage_build_i,
  input wire gfs_fire_t  gate_fire_o,
  input wire logic [5:0] gate_on_o,
  input wire gfs_disp_s  disp_o,
  input wire gfs_log_s   log_o,
  input wire logic       sys_reset_req_o,
  input wire logic       test_active_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // ==========================================================================
  // Helper logic
  // ==========================================================================
  gfs_disp_s   prev_q;  // Display one cycle back
  logic [31:0] dwell_q; // Cycles the current step has stood

  // Allowed positions of one gate, full build; low build only removes bits
  function automatic gfs_fire_t mask_of(logic [2:0] g);
    gfs_fire_t f;
    f = '0;
    f[(3'h6 - g) % 3] = g[0] ? 6'h15 : 6'h2a;
    return f;
  endfunction

  // Gate that follows g in the firing order
  function automatic logic [2:0] nxt(logic [2:0] g);
    case (g)
      3'h6: return 3'h3;
      3'h3: return 3'h5;
      3'h5: return 3'h2;
      3'h2: return 3'h4;
      default: return 3'h1;
    endcase
  endfunction

  // Dwell counter restarts on any display change or outside the steps
  always_ff @(posedge sys_clk_i)
  begin
    prev_q  <= disp_o;
    dwell_q <= (!resetn_i || !test_active_o || disp_o != prev_q) ? 32'h0 : dwell_q + 32'h1;
  end

  sequence s_entered;
    log_o.valid && log_o.code == EVT_ENTERED;
  endsequence
  sequence s_passed;
    log_o.valid && log_o.code == EVT_PASSED;
  endsequence

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_gates_idle_off: assert property (!test_active_o |-> gate_on_o == 6'h00 && gate_fire_o == '0)
    else $error("gates driven outside a test step");
  a_gate_num_match: assert property (disp_o.mode == DSP_GATE_ON |-> gate_on_o == 6'(6'h01 << (disp_o.gate - 3'h1)))
    else $error("shown gate differs from energised gate");
  a_fire_map: assert property (disp_o.mode == DSP_GATE_ON |-> (gate_fire_o & ~mask_of(disp_o.gate)) == '0 && gate_fire_o != '0)
    else $error("gate fires wrong phase or positions");
  a_gate_order: assert property (disp_o.mode == DSP_GATE_ON && $past(disp_o.mode) == DSP_GATE_ON
    && disp_o.gate != $past(disp_o.gate) |-> disp_o.gate == nxt($past(disp_o.gate)))
    else $error("gate step out of order");
  a_all_entry: assert property ($rose(disp_o.mode == DSP_ALL_ON) |-> $past(disp_o.mode) == DSP_GATE_ON
    && $past(disp_o.gate) == 3'h1)
    else $error("all gates step not after gate one");
  a_all_gates_on: assert property (disp_o.mode == DSP_ALL_ON |-> (gate_fire_o & {3{6'h0f}}) == {3{6'h0f}})
    else $error("not every gate fired in all gates step");
  a_pass_reset: assert property (s_passed |=> sys_reset_req_o ##1 !sys_reset_req_o)
    else $error("pass not followed by one reset pulse");
  a_reset_cause: assert property ($rose(sys_reset_req_o) |-> $past(log_o.valid) && $past(log_o.code) == EVT_PASSED)
    else $error("reset request without pass entry");
  a_abort_off: assert property (log_o.valid && log_o.code < 8'd100 |-> gate_fire_o == '0
    && disp_o.mode == DSP_CANCEL ##1 !test_active_o)
    else $error("abort left gates on");
  a_entry_next: assert property (s_entered |=> (disp_o.mode == DSP_GATE_ON && disp_o.gate == 3'h6)
    || disp_o.mode inside {DSP_OPEN_SW, DSP_CANCEL})
    else $error("entry not followed by prompt or gate six");
  a_step_bound: assert property (dwell_q <= STEP_LEN + 32'd2)
    else $error("step outlived its duration");
endmodule

bind gfs_sequencer gfs_seq_props #(.STEP_LEN(STEP_LEN)) u_props (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .standard_selftest_command_i(standard_selftest_command_i),
  .advance_btn_i(advance_btn_i), .disconnect_closed_i(disconnect_closed_i), .line_power_i(line_power_i),
  .low_voltage_build_i(low_voltage_build_i), .gate_fire_o(gate_fire_o), .gate_on_o(gate_on_o),
  .disp_o(disp_o), .log_o(log_o), .sys_reset_req_o(sys_reset_req_o), .test_active_o(test_active_o)
);

// ==== tb/gfs_sequencer_tb.sv ====
// Testbench for the gate firing self-test sequencer.
// Assumes a short STEP_LEN so that timed steps finish quickly.
module gfs_sequencer_tb
  import gfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned STEP = 50; // Shortened step length
  logic clk = 1'b0;
  logic rstn, cmd, discon, line, low, press_req, btn, op_busy, rst_req, active;
  gfs_fire_t  fire;
  logic [5:0] gate_on;
  gfs_disp_s  disp;
  gfs_log_s   log_e;
  int bad_count = 0;
  int compares = 0;
  int ord[6] = '{6, 3, 5, 2, 4, 1};
  logic [31:0] cyc = 32'h0; // Edges since reset release, mirrors the log timestamp

  always #5 clk = ~clk;

  // Timestamp reference: cleared in reset, one step per edge after it
  always @(posedge clk)
    cyc <= rstn ? cyc + 32'h1 : 32'h0;

  gfs_operator_model u_op (.sys_clk_i(clk), .press_req_i(press_req), .advance_btn_o(btn), .busy_o(op_busy));
  gfs_sequencer #(.STEP_LEN(STEP)) dut (
    .sys_clk_i(clk), .resetn_i(rstn), .standard_selftest_command_i(cmd), .advance_btn_i(btn),
    .disconnect_closed_i(discon), .line_power_i(line), .low_voltage_build_i(low), .gate_fire_o(fire),
    .gate_on_o(gate_on), .disp_o(disp), .log_o(log_e), .sys_reset_req_o(rst_req), .test_active_o(active));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Expected pattern; gate 0 stands for the all gates step
  function automatic gfs_fire_t exp_fire(int g, bit lo);
    gfs_fire_t f;
    f = {3{6'h3f}};
    if (g != 0)
    begin
      f = '0;
      f[(6 - g) % 3] = g[0] ? 6'h15 : 6'h2a;
    end
    if (lo)
      f = f & {3{6'h0f}};
    return f;
  endfunction

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic wait_disp(gfs_disp_e m, int g);
    for (int i = 0; i < 150 && !(disp.mode === m && (m != DSP_GATE_ON || disp.gate === 3'(g))); i++)
      tick();
    chk(disp, {m, 3'(g)});
  endtask

  task automatic wait_log(logic [7:0] code, int n);
    for (int i = 0; i < n && log_e.valid !== 1'b1; i++)
      tick();
    chk({log_e.valid, log_e.code}, {1'b1, code});
    chk(log_e.stamp, cyc - 32'h1);
  endtask

  // One self-test: ab is the step index at which cause c aborts, 7 for none
  task automatic run(bit lo, bit prs, int ab, int c, bit pr);
    int g;
    @(posedge clk);
    low    <= lo;
    discon <= pr;
    cmd    <= 1'b1;
    wait_log(EVT_ENTERED, 10);
    if (pr)
    begin
      wait_disp(DSP_OPEN_SW, 0);
      chk(gate_on, 6'h00);
      @(posedge clk);
      discon <= 1'b0;
    end
    for (int k = 0; k < 7; k++)
    begin
      g = (k < 6) ? ord[k] : 0;
      wait_disp(k < 6 ? DSP_GATE_ON : DSP_ALL_ON, g);
      chk(fire, exp_fire(g, lo));
      chk(gate_on, g == 0 ? 6'h3f : 6'(1 << (g - 1)));
      chk(active, 1'b1);
      if (k == ab)
      begin
        @(posedge clk);
        if (c == 0) cmd <= 1'b0;
        else if (c == 1) line <= 1'b1;
        else discon <= 1'b1;
        wait_log(c == 0 ? FLT_CMD_GONE : (c == 1 ? FLT_LINE_POWER : FLT_DISCONNECT), 6);
        chk({fire, gate_on}, 24'h0);
        chk(disp.mode, DSP_CANCEL);
        chk(active, 1'b0);
        break;
      end
      if (prs)
      begin
        @(posedge clk);
        while (op_busy) @(posedge clk);
        press_req <= 1'b1;
        @(posedge clk);
        press_req <= 1'b0;
      end
    end
    if (ab > 6)
    begin
      wait_log(EVT_PASSED, 150);
      chk(disp.mode, DSP_PASSED);
      tick();
      chk(rst_req, 1'b1);
    end
    @(posedge clk);
    cmd    <= 1'b0;
    line   <= 1'b0;
    discon <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic give_verdict();
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial
  begin
    {rstn, cmd, discon, line, low, press_req} = '0;
    void'($urandom(58136));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    run(1'b0, 1'b1, 7, 0, 1'b0);
    run(1'b1, 1'b0, 7, 0, 1'b1);
    for (int c = 0; c < 3; c++)
      run(1'b0, 1'b1, 3 * c, c, 1'b0);
    repeat (6)
      run(1'($urandom_range(1, 0)), 1'($urandom_range(1, 0)), int'($urandom_range(7, 0)),
          int'($urandom_range(2, 0)), 1'($urandom_range(1, 0)));
    give_verdict();
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
endmodule
